// ===== common/sio_pkg.sv
package sio_pkg;

   // Core clock
   localparam int CLK_PERIOD_NS = 50;

   // Four-level strap codes, ordered by pin voltage
   typedef enum logic [1:0] {
      LVL_L = 2'h0,
      LVL_R = 2'h1,
      LVL_F = 2'h2,
      LVL_H = 2'h3
   } sio_lvl_e;

   // Strap thresholds in thousandths of the supply (comparators sit in the analog front end)
   localparam int THR_LR_PERMILLE = 200;
   localparam int THR_RF_PERMILLE = 500;
   localparam int THR_FH_PERMILLE = 800;

   // Rate reported by the recovery loop
   typedef enum logic [2:0] {
      RATE_NONE = 3'h0,
      RATE_3G = 3'h1,
      RATE_HD = 3'h2,
      RATE_SD = 3'h3,
      RATE_125 = 3'h4
   } sio_rate_e;

   // Power state
   typedef enum logic [1:0] {
      PWR_DOWN = 2'h0,
      PWR_SAVE = 2'h1,
      PWR_NORMAL = 2'h2
   } sio_pwr_e;

   // Adapt state machine, one-hot
   typedef enum logic [3:0] {
      AD_IDLE = 4'h1,
      AD_APPLY = 4'h2,
      AD_MEAS = 4'h4,
      AD_DONE = 4'h8
   } sio_adapt_e;

   // Fixed boost values per host equalizer strap level
   localparam logic [7:0] BOOST_H = 8'h00;
   localparam logic [7:0] BOOST_F_LOW = 8'h00;
   localparam logic [7:0] BOOST_R = 8'h80;
   localparam logic [7:0] BOOST_L = 8'h90;

   // Adapt boost table: 16 entries at 0x40-0x4f
   localparam logic [7:0] TBL_BASE = 8'h40;
   localparam int TBL_DEPTH = 16;
   localparam int TBL_AW = 4;
   localparam logic [3:0] TBL_LAST = 4'hf;
   localparam logic [3:0] TBL_RST_STEP = 4'h1;

   // Reset values
   localparam logic [7:0] RST_BOOST = 8'h00;
   localparam logic [7:0] RST_METRIC = 8'h00;

   // Recovery loop reset pulse, least time
   localparam int CDR_RST_NS = 200;
   localparam int CDR_RST_CYC = (CDR_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Settling time per adapt candidate, least time
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 8;

endpackage

// ===== hw/sio_strap_res.sv
`timescale 1ns/1ns
module sio_strap_res
   import sio_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] cmp_raw,
   output sio_lvl_e level,
   output logic valid
);

   logic [2:0] s1_reg;
   logic [2:0] s2_reg;
   logic [2:0] s3_reg;
   logic [2:0] fill_reg;

   // Thermometer to level; a broken code follows the highest comparator set
   function automatic sio_lvl_e therm_to_lvl(input logic [2:0] t);
      if (t[2]) begin
         therm_to_lvl = LVL_H;
      end else if (t[1]) begin
         therm_to_lvl = LVL_F;
      end else if (t[0]) begin
         therm_to_lvl = LVL_R;
      end else begin
         therm_to_lvl = LVL_L;
      end
   endfunction

   // Three-stage pin synchroniser
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s1_reg <= 3'h0;
         s2_reg <= 3'h0;
         s3_reg <= 3'h0;
         fill_reg <= 3'h0;
      end else begin
         s1_reg <= cmp_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         fill_reg <= {fill_reg[1:0], 1'b1};
      end
   end

   // Level taken only once stages two and three agree, so a slow ramp cannot glitch.
   // Held off until real pin samples fill the chain; the reset zeros would
   // otherwise settle as low and make the first true strap look like a change.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         level <= LVL_L;
         valid <= 1'b0;
      end else if (fill_reg[2] && (s2_reg == s3_reg)) begin
         level <= therm_to_lvl(s3_reg);
         valid <= 1'b1;
      end
   end

endmodule

// ===== hw/sio_route_ctrl.sv
`timescale 1ns/1ns
// Operation
// - Direction low: coax input, host output on, coax driver powered down.
// - Direction high: host input drives coax, coax equalizer powered down.
// - Unused port direction powers down automatically from the strap level.
// - Direction change after power-up issues a recovery-loop reset.
// - Receive: host output always on; second output follows loop-through select low.
// - Drive: host output select low enables host loopback monitor.
// - Drive: loop-through select low enables second coax driver.
// - Carrier detection on the selected input decides normal operation.
// - No carrier enters power save; carrier return resumes normal operation.
// - Enable low forces power-down whatever the direction.
// - Power save keeps detector and serial port; power-down keeps serial port.
// - Carrier state readable; optional active-low carrier-absent flag on lock pin.
// - Receive mode offers register-selected reduced launch amplitude input.
// - Host equalizer: fixed boost or auto search over 16 table entries.
// - Drive strap decode: H 0x00, F auto at 3G, R 0x80, L 0x90.
// - Register overrides replace strap adapt mode and boost.
// - Receive mode ignores host equalizer strap boost settings.
// - Reclocker on for 3G, HD and SD rates; bypassed at 125 Mbps.
// - Straps resolve to four levels at 0.2, 0.5, 0.8 supply.
module sio_route_ctrl
   import sio_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [2:0] direction_select_cmp,
   input wire logic [2:0] host_output_select_cmp,
   input wire logic [2:0] loopthru_select_cmp,
   input wire logic [2:0] host_eq_strap_cmp,
   input wire logic enable_pin,
   input wire logic coax_cd_raw,
   input wire logic host_cd_raw,
   input wire logic cdr_lock_n,
   input wire logic [2:0] cdr_rate,
   input wire logic [7:0] eye_metric,
   input wire logic cfg_splitter_en,
   input wire logic cfg_lock_pin_cd,
   input wire logic cfg_eq_ovr_en,
   input wire logic cfg_eq_ovr_auto,
   input wire logic [7:0] cfg_eq_ovr_boost,
   input wire logic tbl_wr_en,
   input wire logic [7:0] tbl_wr_addr,
   input wire logic [7:0] tbl_wr_data,
   input wire logic [7:0] tbl_rd_addr,
   output logic [7:0] tbl_rd_data_reg,
   output logic drive_mode_reg,
   output logic [1:0] pwr_state_reg,
   output logic coax_eq_pwr_reg,
   output logic coax_drv_pwr_reg,
   output logic host_eq_pwr_reg,
   output logic host_out_en_reg,
   output logic host_loopback_reg,
   output logic second_out_en_reg,
   output logic carrier_det_en_reg,
   output logic serial_if_en_reg,
   output logic carrier_status_reg,
   output logic lock_pin_n_reg,
   output logic splitter_atten_reg,
   output logic reclock_en_reg,
   output logic cdr_reset_reg,
   output logic host_eq_auto_reg,
   output logic [7:0] host_eq_boost_reg,
   output logic adapt_done_reg
);

   // Strap resolution
   sio_lvl_e lvl [4];
   logic [3:0] lvl_valid;
   logic [2:0] strap_cmp [4];

   assign strap_cmp[0] = direction_select_cmp;
   assign strap_cmp[1] = host_output_select_cmp;
   assign strap_cmp[2] = loopthru_select_cmp;
   assign strap_cmp[3] = host_eq_strap_cmp;

   // One resolver per four-level strap
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_strap
         sio_strap_res u_res (
            .core_clk(core_clk),
            .sys_rst(sys_rst),
            .cmp_raw(strap_cmp[gi]),
            .level(lvl[gi]),
            .valid(lvl_valid[gi])
         );
      end
   endgenerate

   // Two-level pins: enable, coax carrier, host carrier
   logic [2:0] pin_raw;
   logic [2:0] p1_reg;
   logic [2:0] p2_reg;
   logic [2:0] p3_reg;
   logic [2:0] pin_reg;

   assign pin_raw = {host_cd_raw, coax_cd_raw, enable_pin};

   // Three-stage synchroniser shared by the async pins
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         p1_reg <= 3'h0;
         p2_reg <= 3'h0;
         p3_reg <= 3'h0;
      end else begin
         p1_reg <= pin_raw;
         p2_reg <= p1_reg;
         p3_reg <= p2_reg;
      end
   end

   // Per-bit acceptance once stages two and three agree; one process keeps one driver
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_reg <= 3'h0;
      end else begin
         for (int i = 0; i < 3; i++) begin
            if (p2_reg[i] == p3_reg[i]) begin
               pin_reg[i] <= p3_reg[i];
            end
         end
      end
   end

   // A two-level pin reads F or H as high
   function automatic logic lvl_high(input sio_lvl_e l);
      lvl_high = (l == LVL_F) || (l == LVL_H);
   endfunction

   // Boost table and adapt state
   logic [7:0] boost_tbl [TBL_DEPTH];
   sio_adapt_e ad_state_reg;
   logic [TBL_AW-1:0] ad_idx_reg;
   logic [CNT_W-1:0] ad_cnt_reg;
   logic [7:0] ad_best_metric_reg;
   logic [7:0] ad_best_boost_reg;
   logic [7:0] ad_cand_reg;
   logic [CNT_W-1:0] rst_cnt_reg;
   logic dir_seen_reg;
   logic dir_prev_reg;

   // Decoded next values
   logic drive_next;
   logic carrier_next;
   sio_pwr_e pwr_next;
   logic normal_next;
   logic auto_next;
   logic [7:0] fixed_boost_next;
   logic dir_change;

   // Live decode from current levels, carrier and overrides
   always_comb begin
      drive_next = lvl_high(lvl[0]);
      carrier_next = drive_next ? pin_reg[2] : pin_reg[1];
      if (!pin_reg[0]) begin
         pwr_next = PWR_DOWN;
      end else if (!carrier_next) begin
         pwr_next = PWR_SAVE;
      end else begin
         pwr_next = PWR_NORMAL;
      end
      normal_next = (pwr_next == PWR_NORMAL);
      auto_next = 1'b0;
      fixed_boost_next = RST_BOOST;
      if (drive_next) begin
         if (cfg_eq_ovr_en) begin
            auto_next = cfg_eq_ovr_auto;
            fixed_boost_next = cfg_eq_ovr_boost;
         end else begin
            case (lvl[3])
               LVL_H: fixed_boost_next = BOOST_H;
               LVL_F: begin
                  auto_next = (cdr_rate == RATE_3G);
                  fixed_boost_next = BOOST_F_LOW;
               end
               LVL_R: fixed_boost_next = BOOST_R;
               LVL_L: fixed_boost_next = BOOST_L;
               default: fixed_boost_next = BOOST_H;
            endcase
         end
      end
   end

   assign dir_change = dir_seen_reg && (drive_next != dir_prev_reg);

   // Route and power outputs, registered
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         drive_mode_reg <= 1'b0;
         pwr_state_reg <= PWR_DOWN;
         coax_eq_pwr_reg <= 1'b0;
         coax_drv_pwr_reg <= 1'b0;
         host_eq_pwr_reg <= 1'b0;
         host_out_en_reg <= 1'b0;
         host_loopback_reg <= 1'b0;
         second_out_en_reg <= 1'b0;
         carrier_det_en_reg <= 1'b0;
         serial_if_en_reg <= 1'b0;
         splitter_atten_reg <= 1'b0;
         reclock_en_reg <= 1'b0;
      end else begin
         drive_mode_reg <= drive_next;
         pwr_state_reg <= pwr_next;
         // Only one coax direction powered at a time
         coax_eq_pwr_reg <= normal_next && !drive_next;
         coax_drv_pwr_reg <= normal_next && drive_next;
         host_eq_pwr_reg <= normal_next && drive_next;
         host_out_en_reg <= normal_next && (!drive_next || !lvl_high(lvl[1]));
         host_loopback_reg <= normal_next && drive_next && !lvl_high(lvl[1]);
         second_out_en_reg <= normal_next && !lvl_high(lvl[2]);
         carrier_det_en_reg <= (pwr_next != PWR_DOWN);
         serial_if_en_reg <= 1'b1;
         splitter_atten_reg <= normal_next && !drive_next && cfg_splitter_en;
         reclock_en_reg <= normal_next && (cdr_rate != RATE_125);
      end
   end

   // Carrier status and lock pin
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         carrier_status_reg <= 1'b0;
         lock_pin_n_reg <= 1'b1;
      end else begin
         carrier_status_reg <= carrier_next && pin_reg[0];
         lock_pin_n_reg <= cfg_lock_pin_cd ? carrier_next : cdr_lock_n;
      end
   end

   // Recovery-loop reset on direction change; first settled level is the strap, not a change
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         dir_seen_reg <= 1'b0;
         dir_prev_reg <= 1'b0;
         rst_cnt_reg <= '0;
         cdr_reset_reg <= 1'b0;
      end else begin
         if (!dir_seen_reg && lvl_valid[0]) begin
            dir_seen_reg <= 1'b1;
            dir_prev_reg <= drive_next;
         end
         if (dir_change) begin
            dir_prev_reg <= drive_next;
            rst_cnt_reg <= CNT_W'(CDR_RST_CYC - 1);
            cdr_reset_reg <= 1'b1;
         end else if (rst_cnt_reg != '0) begin
            rst_cnt_reg <= rst_cnt_reg - 1'b1;
         end else begin
            cdr_reset_reg <= 1'b0;
         end
      end
   end

   // Boost table writes, decoded against the table window
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < TBL_DEPTH; i++) begin
            boost_tbl[i] <= {4'(i) * TBL_RST_STEP, 4'h0};
         end
      end else if (tbl_wr_en && (tbl_wr_addr[7:TBL_AW] == TBL_BASE[7:TBL_AW])) begin
         boost_tbl[tbl_wr_addr[TBL_AW-1:0]] <= tbl_wr_data;
      end
   end

   // Table readback; outside the window reads zero
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tbl_rd_data_reg <= 8'h00;
      end else if (tbl_rd_addr[7:TBL_AW] == TBL_BASE[7:TBL_AW]) begin
         tbl_rd_data_reg <= boost_tbl[tbl_rd_addr[TBL_AW-1:0]];
      end else begin
         tbl_rd_data_reg <= 8'h00;
      end
   end

   // Adapt search: try each entry, let it settle, keep the best eye metric.
   // Restarts on a recovery-loop reset since the old result belongs to the old input.
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ad_state_reg <= AD_IDLE;
         ad_idx_reg <= '0;
         ad_cnt_reg <= '0;
         ad_best_metric_reg <= RST_METRIC;
         ad_best_boost_reg <= RST_BOOST;
         ad_cand_reg <= RST_BOOST;
      end else if (!(auto_next && host_eq_pwr_reg) || cdr_reset_reg) begin
         ad_state_reg <= AD_IDLE;
      end else begin
         case (ad_state_reg)
            AD_IDLE: begin
               ad_idx_reg <= '0;
               ad_best_metric_reg <= RST_METRIC;
               ad_best_boost_reg <= boost_tbl[0];
               ad_state_reg <= AD_APPLY;
               ad_cnt_reg <= CNT_W'(SETTLE_CYC - 1);
               ad_cand_reg <= boost_tbl[0];
            end
            AD_APPLY: begin
               if (ad_cnt_reg == '0) begin
                  ad_state_reg <= AD_MEAS;
               end else begin
                  ad_cnt_reg <= ad_cnt_reg - 1'b1;
               end
            end
            AD_MEAS: begin
               if (eye_metric > ad_best_metric_reg) begin
                  ad_best_metric_reg <= eye_metric;
                  ad_best_boost_reg <= ad_cand_reg;
               end
               if (ad_idx_reg == TBL_LAST) begin
                  ad_state_reg <= AD_DONE;
               end else begin
                  ad_idx_reg <= ad_idx_reg + 1'b1;
                  ad_cand_reg <= boost_tbl[ad_idx_reg + 1'b1];
                  ad_cnt_reg <= CNT_W'(SETTLE_CYC - 1);
                  ad_state_reg <= AD_APPLY;
               end
            end
            AD_DONE: ad_state_reg <= AD_DONE;
            default: ad_state_reg <= AD_IDLE;
         endcase
      end
   end

   // Equalizer setting: candidate during search, winner after, fixed otherwise
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         host_eq_auto_reg <= 1'b0;
         host_eq_boost_reg <= RST_BOOST;
         adapt_done_reg <= 1'b0;
      end else begin
         host_eq_auto_reg <= auto_next;
         adapt_done_reg <= auto_next && (ad_state_reg == AD_DONE);
         if (!auto_next) begin
            host_eq_boost_reg <= fixed_boost_next;
         end else if (ad_state_reg == AD_DONE) begin
            host_eq_boost_reg <= ad_best_boost_reg;
         end else begin
            host_eq_boost_reg <= ad_cand_reg;
         end
      end
   end

endmodule

// ===== testbench/sio_route_chk.sv
`timescale 1ns/1ns
module sio_route_chk
   import sio_pkg::*;
(
   input logic core_clk,
   input logic sys_rst,
   input logic [2:0] cdr_rate,
   input logic cfg_lock_pin_cd,
   input logic drive_mode_reg,
   input logic [1:0] pwr_state_reg,
   input logic coax_eq_pwr_reg,
   input logic coax_drv_pwr_reg,
   input logic host_eq_pwr_reg,
   input logic host_out_en_reg,
   input logic host_loopback_reg,
   input logic second_out_en_reg,
   input logic carrier_det_en_reg,
   input logic lock_pin_n_reg,
   input logic reclock_en_reg,
   input logic cdr_reset_reg,
   input logic host_eq_auto_reg,
   input logic [7:0] host_eq_boost_reg
);
   // All checks live in the core clock domain
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   AST_RECV_ROUTE: assert property (pwr_state_reg == 2'h2 && !drive_mode_reg |->
      coax_eq_pwr_reg && !coax_drv_pwr_reg && host_out_en_reg) else $error("receive route wrong");
   AST_DRV_ROUTE: assert property (pwr_state_reg == 2'h2 && drive_mode_reg |->
      coax_drv_pwr_reg && !coax_eq_pwr_reg && host_eq_pwr_reg) else $error("drive route wrong");
   AST_ONE_DIR: assert property (!(coax_eq_pwr_reg && coax_drv_pwr_reg))
      else $error("both coax directions powered");
   AST_CDR_CAUSE: assert property ($rose(cdr_reset_reg) |-> drive_mode_reg != $past(drive_mode_reg))
      else $error("recovery reset without direction change");
   AST_CDR_LEN: assert property ($rose(cdr_reset_reg) |-> cdr_reset_reg [*4])
      else $error("recovery reset pulse too short");
   AST_LOOPBACK: assert property (host_loopback_reg |-> drive_mode_reg && host_out_en_reg)
      else $error("loopback outside drive mode");
   AST_PWR_DOWN: assert property (pwr_state_reg == 2'h0 |-> !host_out_en_reg && !second_out_en_reg
      && !reclock_en_reg && !carrier_det_en_reg && !host_eq_pwr_reg) else $error("power down leaves paths on");
   AST_PWR_SAVE: assert property (pwr_state_reg == 2'h1 |-> carrier_det_en_reg && !coax_eq_pwr_reg
      && !coax_drv_pwr_reg && !host_out_en_reg) else $error("power save state wrong");
   AST_LOCK_PIN: assert property (pwr_state_reg == 2'h2 && cfg_lock_pin_cd && $past(cfg_lock_pin_cd)
      |-> lock_pin_n_reg) else $error("carrier flag low with carrier");
   AST_RECLK: assert property (reclock_en_reg |-> pwr_state_reg == 2'h2 && $past(cdr_rate) != 3'h4)
      else $error("reclocker on at bypass rate");
   AST_RX_EQ: assert property (pwr_state_reg == 2'h2 && !drive_mode_reg |->
      !host_eq_auto_reg && host_eq_boost_reg == 8'h00) else $error("host eq active in receive");
endmodule

bind sio_route_ctrl sio_route_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .cdr_rate(cdr_rate),
   .cfg_lock_pin_cd(cfg_lock_pin_cd), .drive_mode_reg(drive_mode_reg), .pwr_state_reg(pwr_state_reg),
   .coax_eq_pwr_reg(coax_eq_pwr_reg), .coax_drv_pwr_reg(coax_drv_pwr_reg), .host_eq_pwr_reg(host_eq_pwr_reg),
   .host_out_en_reg(host_out_en_reg), .host_loopback_reg(host_loopback_reg),
   .second_out_en_reg(second_out_en_reg), .carrier_det_en_reg(carrier_det_en_reg),
   .lock_pin_n_reg(lock_pin_n_reg), .reclock_en_reg(reclock_en_reg), .cdr_reset_reg(cdr_reset_reg),
   .host_eq_auto_reg(host_eq_auto_reg), .host_eq_boost_reg(host_eq_boost_reg));

// ===== testbench/sio_board_model.sv
`timescale 1ns/1ns
module sio_board_model
   import sio_pkg::*;
(
   input sio_lvl_e dir_lvl,
   input sio_lvl_e os_lvl,
   input sio_lvl_e lt_lvl,
   input sio_lvl_e eq_lvl,
   input logic [7:0] boost_seen,
   input logic [7:0] best_boost,
   output logic [2:0] dir_cmp,
   output logic [2:0] os_cmp,
   output logic [2:0] lt_cmp,
   output logic [2:0] eq_cmp,
   output logic [7:0] eye
);
   // Thermometer code of the three comparators at 0.2, 0.5, 0.8 supply
   function automatic logic [2:0] therm(sio_lvl_e l);
      return 3'h7 >> (2'h3 - l);
   endfunction

   // Straps always sit at one defined level; no floating between values
   assign dir_cmp = therm(dir_lvl);
   assign os_cmp = therm(os_lvl);
   assign lt_cmp = therm(lt_lvl);
   assign eq_cmp = therm(eq_lvl);
   // Eye opens only at the one good boost, so the search has a single winner
   assign eye = (boost_seen == best_boost) ? 8'hc0 : 8'h20;
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import sio_pkg::*;
   logic core_clk, sys_rst, enable_pin, coax_cd_raw, host_cd_raw, cdr_lock_n;
   logic [2:0] dcmp, ocmp, lcmp, ecmp, cdr_rate;
   logic [7:0] eye_metric, cfg_eq_ovr_boost, tbl_wr_addr, tbl_wr_data, tbl_rd_addr, tbl_rd_data_reg;
   logic cfg_splitter_en, cfg_lock_pin_cd, cfg_eq_ovr_en, cfg_eq_ovr_auto, tbl_wr_en;
   logic drive_mode_reg, coax_eq_pwr_reg, coax_drv_pwr_reg, host_eq_pwr_reg, host_out_en_reg;
   logic host_loopback_reg, second_out_en_reg, carrier_det_en_reg, serial_if_en_reg, carrier_status_reg;
   logic lock_pin_n_reg, splitter_atten_reg, reclock_en_reg, cdr_reset_reg, host_eq_auto_reg, adapt_done_reg;
   logic [1:0] pwr_state_reg;
   logic [7:0] host_eq_boost_reg;
   sio_lvl_e dl, ol, ll, el;
   int bad_count, total_checks, c;

   sio_board_model u_brd (.dir_lvl(dl), .os_lvl(ol), .lt_lvl(ll), .eq_lvl(el), .boost_seen(host_eq_boost_reg),
      .best_boost(8'h19), .dir_cmp(dcmp), .os_cmp(ocmp), .lt_cmp(lcmp), .eq_cmp(ecmp), .eye(eye_metric));

   sio_route_ctrl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .direction_select_cmp(dcmp),
      .host_output_select_cmp(ocmp), .loopthru_select_cmp(lcmp), .host_eq_strap_cmp(ecmp),
      .enable_pin(enable_pin), .coax_cd_raw(coax_cd_raw), .host_cd_raw(host_cd_raw), .cdr_lock_n(cdr_lock_n),
      .cdr_rate(cdr_rate), .eye_metric(eye_metric), .cfg_splitter_en(cfg_splitter_en),
      .cfg_lock_pin_cd(cfg_lock_pin_cd), .cfg_eq_ovr_en(cfg_eq_ovr_en), .cfg_eq_ovr_auto(cfg_eq_ovr_auto),
      .cfg_eq_ovr_boost(cfg_eq_ovr_boost), .tbl_wr_en(tbl_wr_en), .tbl_wr_addr(tbl_wr_addr),
      .tbl_wr_data(tbl_wr_data), .tbl_rd_addr(tbl_rd_addr), .tbl_rd_data_reg(tbl_rd_data_reg),
      .drive_mode_reg(drive_mode_reg), .pwr_state_reg(pwr_state_reg), .coax_eq_pwr_reg(coax_eq_pwr_reg),
      .coax_drv_pwr_reg(coax_drv_pwr_reg), .host_eq_pwr_reg(host_eq_pwr_reg), .host_out_en_reg(host_out_en_reg),
      .host_loopback_reg(host_loopback_reg), .second_out_en_reg(second_out_en_reg),
      .carrier_det_en_reg(carrier_det_en_reg), .serial_if_en_reg(serial_if_en_reg),
      .carrier_status_reg(carrier_status_reg), .lock_pin_n_reg(lock_pin_n_reg),
      .splitter_atten_reg(splitter_atten_reg), .reclock_en_reg(reclock_en_reg), .cdr_reset_reg(cdr_reset_reg),
      .host_eq_auto_reg(host_eq_auto_reg), .host_eq_boost_reg(host_eq_boost_reg),
      .adapt_done_reg(adapt_done_reg));

   // Free-running core clock, 50 ns
   initial begin
      core_clk = 1'b0;
      forever #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   end

   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude();
      if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic step(int n);
      repeat (n) @(posedge core_clk);
   endtask

   // Count cycles with the recovery reset high over a window
   task automatic cnt_rst(int n, output int k);
      k = 0;
      repeat (n) begin
         @(negedge core_clk);
         if (cdr_reset_reg === 1'b1) k++;
      end
   endtask

   // Reference decode from pin levels; four-level straps read two-level as L,R low
   task automatic check_all();
      int drv, os_lo, lt_lo, sel, pw, nrm, au;
      logic [7:0] bst;
      @(negedge core_clk);
      drv = (dl >= LVL_F);
      os_lo = (ol <= LVL_R);
      lt_lo = (ll <= LVL_R);
      sel = drv ? host_cd_raw : coax_cd_raw;
      pw = !enable_pin ? 0 : (sel ? 2 : 1);
      nrm = (pw == 2);
      au = drv && (cfg_eq_ovr_en ? cfg_eq_ovr_auto : (el == LVL_F && cdr_rate == 3'h1));
      bst = (el == LVL_R) ? 8'h80 : (el == LVL_L) ? 8'h90 : 8'h00;
      if (cfg_eq_ovr_en) bst = cfg_eq_ovr_boost;
      if (!drv) bst = 8'h00;
      chk("drive_mode", drive_mode_reg, drv);
      chk("pwr_state", pwr_state_reg, pw);
      chk("coax_eq", coax_eq_pwr_reg, nrm && !drv);
      chk("coax_drv", coax_drv_pwr_reg, nrm && drv);
      chk("host_eq", host_eq_pwr_reg, nrm && drv);
      chk("host_out", host_out_en_reg, nrm && (!drv || os_lo));
      chk("loopback", host_loopback_reg, nrm && drv && os_lo);
      chk("second_out", second_out_en_reg, nrm && lt_lo);
      chk("detector", carrier_det_en_reg, enable_pin);
      chk("serial_if", serial_if_en_reg, 1);
      chk("carrier", carrier_status_reg, sel && enable_pin);
      chk("lock_pin", lock_pin_n_reg, cfg_lock_pin_cd ? sel : cdr_lock_n);
      chk("reclock", reclock_en_reg, nrm && cdr_rate != 3'h4);
      chk("splitter", splitter_atten_reg, nrm && !drv && cfg_splitter_en);
      chk("eq_auto", host_eq_auto_reg, au);
      if (!au) chk("eq_boost", host_eq_boost_reg, bst);
   endtask

   initial begin
      bad_count = 0;
      total_checks = 0;
      {enable_pin, coax_cd_raw, host_cd_raw, cdr_lock_n, cfg_splitter_en, cfg_lock_pin_cd} = 6'h3f;
      {cfg_eq_ovr_en, cfg_eq_ovr_auto, tbl_wr_en} = 3'h0;
      {cdr_rate, cfg_eq_ovr_boost, tbl_wr_addr, tbl_wr_data, tbl_rd_addr} = {3'h2, 32'h0};
      dl = LVL_H;
      ol = LVL_L;
      ll = LVL_H;
      el = LVL_F;
      sys_rst = 1'b1;
      step(8);
      sys_rst <= 1'b0;
      void'($urandom(2));
      // First settled direction must not pulse the recovery reset
      cnt_rst(12, c);
      chk("cdr_rst_first", c, 0);
      check_all();
      // Reset table contents and out-of-window reads
      for (int i = 0; i < 16; i += 5) begin
         @(posedge core_clk) tbl_rd_addr <= TBL_BASE + i[7:0];
         step(1);
         @(negedge core_clk) chk("tbl_rst", tbl_rd_data_reg, {i[3:0], 4'h0});
      end
      @(posedge core_clk) {tbl_wr_en, tbl_wr_addr, tbl_wr_data, tbl_rd_addr} <= {1'b1, 8'h50, 8'h77, 8'h50};
      step(2);
      @(negedge core_clk) chk("tbl_outside", tbl_rd_data_reg, 8'h00);
      // Distinct entries, back-to-back writes
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk) {tbl_wr_addr, tbl_wr_data} <= {TBL_BASE + i[7:0], 8'h10 + i[7:0]};
      end
      @(posedge core_clk) {tbl_wr_en, tbl_rd_addr} <= {1'b0, 8'h42};
      step(2);
      @(negedge core_clk) chk("tbl_rd", tbl_rd_data_reg, 8'h12);
      // Direction toggles: each change gives one 4-cycle recovery reset
      @(posedge core_clk) dl <= LVL_L;
      cnt_rst(16, c);
      chk("cdr_rst_rx", c, 4);
      check_all();
      @(posedge core_clk) dl <= LVL_H;
      cnt_rst(16, c);
      chk("cdr_rst_tx", c, 4);
      // Override into automatic search; only entry 9 opens the eye
      @(posedge core_clk) {cfg_eq_ovr_en, cfg_eq_ovr_auto} <= 2'h3;
      c = 0;
      while (adapt_done_reg !== 1'b1 && c < 800) begin
         @(negedge core_clk);
         c++;
      end
      @(negedge core_clk) chk("adapt_done", adapt_done_reg, 1);
      chk("adapt_best", host_eq_boost_reg, 8'h19);
      // Random pin, carrier and config mixes
      for (int n = 0; n < 60; n++) begin
         @(posedge core_clk);
         dl <= sio_lvl_e'($urandom_range(3));
         ol <= sio_lvl_e'($urandom_range(3));
         ll <= sio_lvl_e'($urandom_range(3));
         el <= sio_lvl_e'($urandom_range(3));
         {coax_cd_raw, host_cd_raw, cdr_lock_n, cfg_splitter_en, cfg_lock_pin_cd} <= 5'($urandom);
         {cfg_eq_ovr_en, cfg_eq_ovr_auto, cfg_eq_ovr_boost} <= 10'($urandom);
         enable_pin <= ($urandom_range(3) != 0);
         cdr_rate <= 3'($urandom_range(4));
         step(9);
         check_all();
      end
      conclude();
   end

   // Hang guard, well past the expected run length
   initial begin
      #(4000 * CLK_PERIOD_NS);
      bad_count++;
      conclude();
   end
endmodule
